/* rtl/iosc_pkg.sv */
// Package for the internal oscillator and system clock control block.
// Assumes an 8-bit special function register port on the core clock.
package iosc_pkg;
    // Register addresses in special function register space
    localparam logic [7:0] IOSC_CTRL_ADDR = 8'hB2;
    localparam logic [7:0] IOSC_CAL_ADDR = 8'hB3;
    // Control register fields
    localparam int CTRL_READY_BIT = 4;
    localparam int CTRL_SRC_BIT = 3;
    localparam int CTRL_EN_BIT = 2;
    localparam int CTRL_DIV_LSB = 0;
    localparam logic [7:0] CTRL_RESET = 8'h14;
    // Divider field encodings
    localparam logic [1:0] DIV_BY8 = 2'h0;
    localparam logic [1:0] DIV_BY4 = 2'h1;
    localparam logic [1:0] DIV_BY2 = 2'h2;
    localparam logic [1:0] DIV_BY1 = 2'h3;
    // Calibration: 7-bit field, uncalibrated reset value
    localparam int CAL_W = 7;
    localparam logic [6:0] CAL_UNCAL_RESET = 7'h20;
    // Step per calibration unit, in thousandths of the base period
    localparam int CAL_STEP_PERMILLE = 5;
    // Settling of the oscillator after enable, in ns, and in cycles
    localparam int OSC_SETTLE_NS = 200;
    localparam int CLK_PERIOD_NS = 10;
    localparam int OSC_SETTLE_CYC = (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Oscillator model: half period in clk cycles at calibration 0
    localparam int OSC_HALF_BASE = 4;
endpackage

/* rtl/iosc_glitchfree_mux.sv */
// Glitch-free two-input clock switch working on sampled clock levels.
// Assumes both inputs are already synchronous to clk_i.
`timescale 1ns/1ps
module iosc_glitchfree_mux (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic sel_i,
    input wire logic clk_a_i,
    input wire logic clk_b_i,
    output logic clk_o
);
    logic act_b_ff, nxt_act_b;
    logic clk_ff, nxt_clk;

    // Change selection only while both sources are low: no runt pulses
    always_comb begin
        nxt_act_b = act_b_ff;
        if (sel_i != act_b_ff && !clk_a_i && !clk_b_i && !clk_ff) begin
            nxt_act_b = sel_i;
        end
        nxt_clk = nxt_act_b ? clk_b_i : clk_a_i;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            act_b_ff <= 1'b0;
            clk_ff <= 1'b0;
        end else begin
            act_b_ff <= nxt_act_b;
            clk_ff <= nxt_clk;
        end
    end

    assign clk_o = clk_ff;
endmodule // iosc_glitchfree_mux

/* rtl/iosc_ctrl.sv */
// Internal oscillator control, calibration and system clock selection.
// Assumes the core issues single-cycle SFR reads and writes on clk_i.
// Notes on behaviour
// - After reset the system clock comes from the internal oscillator.
// - Each calibration step changes the oscillator period by 0.005 of the base period.
// - The factory variant resets calibration to a per-device value for 24.5 MHz.
// - The uncalibrated variant always resets calibration to 0x20, nominal 20 MHz.
// - Divider field 00/01/10/11 divides the internal clock by 8/4/2/1.
// - The divider field resets to divide by 8.
// - Control bit 4 is a read-only ready flag, 1 when running at its programmed rate.
// - Control bit 3 selects internal (0) or external (1) source.
// - Control bit 2 enables the internal oscillator.
// - Calibration holds the period in bits 6..0, bit 7 unused.
// - Sources may be switched at any time once the new one is enabled and settled.
`timescale 1ns/1ps
module iosc_ctrl #(
    parameter bit FACTORY_CAL = 1'b0,
    parameter logic [6:0] FACTORY_CAL_VALUE = 7'h40, // Arbitrary per-device value
    parameter int SETTLE_CYC = iosc_pkg::OSC_SETTLE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic ext_osc_i,
    output logic [7:0] sfr_rdata_o,
    output logic internal_osc_ready_flag_o,
    output logic internal_osc_enable_o,
    output logic [6:0] internal_osc_calibration_o,
    output logic system_clock_o
);
    import iosc_pkg::*;

    // Settle counter is 13 bits wide; refuse counts below 1 or above 4096
    if (SETTLE_CYC < 1 || SETTLE_CYC > 4096) begin : g_bad_settle
        $error("SETTLE_CYC out of range");
    end

    localparam logic [6:0] CAL_RESET = FACTORY_CAL ? FACTORY_CAL_VALUE : CAL_UNCAL_RESET;

    // Divide ratio as a shift count for the given field
    function automatic logic [1:0] div_shift(input logic [1:0] f);
        case (f)
            DIV_BY8: div_shift = 2'h3;
            DIV_BY4: div_shift = 2'h2;
            DIV_BY2: div_shift = 2'h1;
            default: div_shift = 2'h0;
        endcase
    endfunction

    typedef enum logic [1:0] {IOSC_OFF, IOSC_SETTLE, IOSC_RUN} iosc_state_t;

    logic [1:0] div_ff, nxt_div;
    logic src_ff, nxt_src;
    logic en_ff, nxt_en;
    logic [6:0] cal_ff, nxt_cal;
    logic [7:0] rdata_ff, nxt_rdata;
    iosc_state_t st_ff, nxt_st;
    logic [12:0] cnt_ff, nxt_cnt;
    logic rdy_ff, nxt_rdy;
    logic [7:0] osc_cnt_ff, nxt_osc_cnt;
    logic osc_ff, nxt_osc;
    logic [3:0] dv_ff, nxt_dv;
    logic int_clk_ff, nxt_int_clk;
    logic ext_s1_ff, ext_s2_ff;
    logic [7:0] half_len;
    logic mux_clk;

    // Register writes; bits 7..4 of control and bit 7 of calibration are dropped
    always_comb begin
        nxt_div = div_ff;
        nxt_src = src_ff;
        nxt_en = en_ff;
        nxt_cal = cal_ff;
        if (sfr_wr_i && sfr_addr_i == IOSC_CTRL_ADDR) begin
            nxt_div = sfr_wdata_i[CTRL_DIV_LSB +: 2];
            nxt_src = sfr_wdata_i[CTRL_SRC_BIT];
            nxt_en = sfr_wdata_i[CTRL_EN_BIT];
        end
        if (sfr_wr_i && sfr_addr_i == IOSC_CAL_ADDR) begin
            nxt_cal = sfr_wdata_i[CAL_W-1:0];
        end
    end

    // Read mux, registered; unmapped addresses read zero
    always_comb begin
        nxt_rdata = rdata_ff;
        if (sfr_rd_i) begin
            nxt_rdata = 8'h00;
            if (sfr_addr_i == IOSC_CTRL_ADDR) begin
                nxt_rdata[CTRL_READY_BIT] = rdy_ff;
                nxt_rdata[CTRL_SRC_BIT] = src_ff;
                nxt_rdata[CTRL_EN_BIT] = en_ff;
                nxt_rdata[CTRL_DIV_LSB +: 2] = div_ff;
            end else if (sfr_addr_i == IOSC_CAL_ADDR) begin
                nxt_rdata = {1'b0, cal_ff};
            end
        end
    end

    // Ready tracking: settle after enable or calibration change
    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_rdy = 1'b0;
        case (st_ff)
            IOSC_OFF: begin
                if (en_ff) begin
                    nxt_st = IOSC_SETTLE;
                    nxt_cnt = 13'h0000;
                end
            end
            IOSC_SETTLE: begin
                nxt_cnt = cnt_ff + 13'h0001;
                if (!en_ff) begin
                    nxt_st = IOSC_OFF;
                end else if (cnt_ff >= 13'(SETTLE_CYC - 1)) begin
                    nxt_st = IOSC_RUN;
                    nxt_rdy = 1'b1;
                end
            end
            IOSC_RUN: begin
                nxt_rdy = 1'b1;
                if (!en_ff) begin
                    nxt_st = IOSC_OFF;
                    nxt_rdy = 1'b0;
                end else if (nxt_cal != cal_ff) begin
                    nxt_st = IOSC_SETTLE;
                    nxt_cnt = 13'h0000;
                    nxt_rdy = 1'b0;
                end
            end
            default: nxt_st = IOSC_OFF;
        endcase
    end

    // Behavioural oscillator: half period grows by 0.005 base per step
    always_comb begin
        half_len = 8'(OSC_HALF_BASE + (int'(cal_ff) * OSC_HALF_BASE * CAL_STEP_PERMILLE) / 1000);
        nxt_osc_cnt = osc_cnt_ff;
        nxt_osc = osc_ff;
        if (!en_ff) begin
            nxt_osc_cnt = 8'h00;
            nxt_osc = 1'b0;
        end else if (osc_cnt_ff + 8'h01 >= half_len) begin
            nxt_osc_cnt = 8'h00;
            nxt_osc = !osc_ff;
        end else begin
            nxt_osc_cnt = osc_cnt_ff + 8'h01;
        end
    end

    // Divider on oscillator edges; all ratios share one counter, so a new
    // ratio keeps the old phase but may leave one pulse shorter than the faster clock.
    // Parked low while off, else the source switch would wait for a low forever.
    always_comb begin
        nxt_dv = dv_ff;
        nxt_int_clk = int_clk_ff;
        if (!en_ff) begin
            nxt_dv = 4'h0;
            nxt_int_clk = 1'b0;
        end else if (nxt_osc && !osc_ff) begin
            nxt_dv = dv_ff + 4'h1;
            if (div_ff == DIV_BY1) begin
                nxt_int_clk = 1'b1;
            end else begin
                nxt_int_clk = nxt_dv[div_shift(div_ff) - 2'h1];
            end
        end else if (!nxt_osc && osc_ff && div_ff == DIV_BY1) begin
            nxt_int_clk = 1'b0;
        end
    end

    // State registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_ff <= CTRL_RESET[CTRL_DIV_LSB +: 2];
            src_ff <= CTRL_RESET[CTRL_SRC_BIT];
            en_ff <= CTRL_RESET[CTRL_EN_BIT];
            cal_ff <= CAL_RESET;
            rdata_ff <= 8'h00;
            st_ff <= IOSC_OFF;
            cnt_ff <= 13'h0000;
            rdy_ff <= 1'b0;
            osc_cnt_ff <= 8'h00;
            osc_ff <= 1'b0;
            dv_ff <= 4'h0;
            int_clk_ff <= 1'b0;
            ext_s1_ff <= 1'b0;
            ext_s2_ff <= 1'b0;
        end else begin
            div_ff <= nxt_div;
            src_ff <= nxt_src;
            en_ff <= nxt_en;
            cal_ff <= nxt_cal;
            rdata_ff <= nxt_rdata;
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            rdy_ff <= nxt_rdy;
            osc_cnt_ff <= nxt_osc_cnt;
            osc_ff <= nxt_osc;
            dv_ff <= nxt_dv;
            int_clk_ff <= nxt_int_clk;
            ext_s1_ff <= ext_osc_i; // Pin from outside, two stages
            ext_s2_ff <= ext_s1_ff;
        end
    end

    // Source switch without runt pulses
    iosc_glitchfree_mux u_mux (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .sel_i(src_ff),
        .clk_a_i(int_clk_ff),
        .clk_b_i(ext_s2_ff),
        .clk_o(mux_clk)
    );

    assign sfr_rdata_o = rdata_ff;
    assign internal_osc_ready_flag_o = rdy_ff;
    assign internal_osc_enable_o = en_ff;
    assign internal_osc_calibration_o = cal_ff;
    assign system_clock_o = mux_clk;

    chk_ready_off_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !en_ff |=> !rdy_ff) else $error("ready set while disabled");
    chk_ready_settle_time: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(rdy_ff) |-> $past(en_ff, 1) && $past(en_ff, 2)) else $error("ready early");
    chk_cal_bit7_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sfr_rd_i && sfr_addr_i == IOSC_CAL_ADDR |=> rdata_ff[7] == 1'b0)
        else $error("cal bit 7 not zero");
    chk_ctrl_write_div: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sfr_wr_i && sfr_addr_i == IOSC_CTRL_ADDR |=> div_ff == $past(sfr_wdata_i[1:0]))
        else $error("divider not written");
    chk_ctrl_write_src: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sfr_wr_i && sfr_addr_i == IOSC_CTRL_ADDR |=> src_ff == $past(sfr_wdata_i[3]))
        else $error("source not written");
    chk_ctrl_write_en: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sfr_wr_i && sfr_addr_i == IOSC_CTRL_ADDR |=> en_ff == $past(sfr_wdata_i[2]))
        else $error("enable not written");
    chk_ctrl_read_ready: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sfr_rd_i && sfr_addr_i == IOSC_CTRL_ADDR |=> rdata_ff[4] == $past(rdy_ff))
        else $error("ready misread");
    chk_osc_stops_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !en_ff |=> !osc_ff) else $error("oscillator runs while off");
    chk_ready_within: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(en_ff) && SETTLE_CYC <= 20 |-> ##[1:25] (rdy_ff || !en_ff))
        else $error("ready late");
    cov_enable_ready: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(rdy_ff));
    cov_switch_ext: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(src_ff));
    cov_div_by1: cover property (@(posedge clk_i) disable iff (!rst_n_i) div_ff == DIV_BY1);
    cov_cal_write: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        sfr_wr_i && sfr_addr_i == IOSC_CAL_ADDR);
endmodule // iosc_ctrl

/* sim/iosc_ctrl_tb.sv */
// Self-checking testbench for the internal oscillator control block.
// Assumes iosc_pkg and iosc_ctrl are compiled first; the bench drives the SFR port itself.
`timescale 1ns/1ps
module iosc_ctrl_tb;
    import iosc_pkg::*;
    localparam int STEP_NS = 1;
    localparam int EXT_PERIOD = 6;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] sfr_addr_i = 8'h00;
    logic [7:0] sfr_wdata_i = 8'h00;
    logic sfr_wr_i = 1'b0;
    logic sfr_rd_i = 1'b0;
    logic ext_osc_i = 1'b0;
    logic [7:0] sfr_rdata_o;
    logic internal_osc_ready_flag_o;
    logic internal_osc_enable_o;
    logic [6:0] internal_osc_calibration_o;
    logic system_clock_o;
    int mismatches = 0;
    int num_checks = 0;
    int ext_cnt = 0;
    int per;
    int per_lo;
    logic [7:0] rdat;

    // Core clock, 100 MHz
    always #5 clk_i = ~clk_i;

    // External oscillator stand-in, toggles every third core cycle
    always @(posedge clk_i) begin
        #STEP_NS;
        ext_cnt = (ext_cnt == EXT_PERIOD / 2 - 1) ? 0 : ext_cnt + 1;
        if (ext_cnt == 0) begin
            ext_osc_i = ~ext_osc_i;
        end
    end

    // Short settle count keeps the run brief
    iosc_ctrl #(.SETTLE_CYC(2)) iosc_ctrl_inst (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .sfr_addr_i(sfr_addr_i),
        .sfr_wdata_i(sfr_wdata_i),
        .sfr_wr_i(sfr_wr_i),
        .sfr_rd_i(sfr_rd_i),
        .ext_osc_i(ext_osc_i),
        .sfr_rdata_o(sfr_rdata_o),
        .internal_osc_ready_flag_o(internal_osc_ready_flag_o),
        .internal_osc_enable_o(internal_osc_enable_o),
        .internal_osc_calibration_o(internal_osc_calibration_o),
        .system_clock_o(system_clock_o)
    );

    task automatic tally_and_finish();
        if (mismatches == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic fail(input string msg);
        mismatches++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            fail(msg);
        end
    endtask

    task automatic check_int(input int got, input int exp, input string msg);
        num_checks++;
        if (got != exp) begin
            fail(msg);
        end
    endtask

    // One-cycle write strobe, released after the taking edge
    task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_i);
        #STEP_NS;
        sfr_addr_i = addr;
        sfr_wdata_i = data;
        sfr_wr_i = 1'b1;
        @(posedge clk_i);
        #STEP_NS;
        sfr_wr_i = 1'b0;
    endtask

    // Read data is registered at the taking edge and holds afterwards
    task automatic sfr_read(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk_i);
        #STEP_NS;
        sfr_addr_i = addr;
        sfr_rd_i = 1'b1;
        @(posedge clk_i);
        #STEP_NS;
        sfr_rd_i = 1'b0;
        data = sfr_rdata_o;
    endtask

    task automatic wait_ready();
        int i;
        for (i = 0; i < 200 && internal_osc_ready_flag_o !== 1'b1; i++) begin
            @(posedge clk_i);
            #STEP_NS;
        end
        num_checks++;
        if (internal_osc_ready_flag_o !== 1'b1) begin
            fail("ready never set");
            tally_and_finish();
        end
    endtask

    // Cycles between two rising edges of the sampled system clock
    task automatic measure_period(output int n);
        logic p;
        int i;
        int edges;
        n = 0;
        edges = 0;
        for (i = 0; i < 600 && edges < 2; i++) begin
            p = system_clock_o;
            @(posedge clk_i);
            #STEP_NS;
            if (edges == 1) n++;
            if (p === 1'b0 && system_clock_o === 1'b1) edges++;
        end
        if (edges < 2) begin
            fail("system clock not toggling");
            tally_and_finish();
        end
    endtask

    // Main sequence; first period after a switch is discarded as it may be partial
    initial begin
        repeat (5) @(posedge clk_i);
        #STEP_NS;
        rst_n_i = 1'b1;
        for (int r = 0; r < 2; r++) begin
            check8({7'h00, internal_osc_enable_o}, 8'h01, "enable not set at reset");
            check8({1'b0, internal_osc_calibration_o}, {1'b0, CAL_UNCAL_RESET}, "cal reset");
            wait_ready();
            sfr_read(IOSC_CTRL_ADDR, rdat);
            check8(rdat, CTRL_RESET, "control reset value");
            sfr_read(IOSC_CAL_ADDR, rdat);
            check8(rdat, {1'b0, CAL_UNCAL_RESET}, "cal read after reset");
            measure_period(per);
            measure_period(per);
            check_int(per, 2 * OSC_HALF_BASE * 8, "reset system clock rate");
            if (r == 0) begin
                // Every divider code, fastest last so it is left selected
                for (int k = 0; k < 4; k++) begin
                    sfr_write(IOSC_CTRL_ADDR, 8'h04 | 8'(k));
                    measure_period(per);
                    measure_period(per);
                    check_int(per, 2 * OSC_HALF_BASE * (8 >> k), "divider ratio");
                end
                // Bit 7 of calibration is dropped; a larger value only slows the oscillator
                sfr_write(IOSC_CAL_ADDR, 8'hFF);
                sfr_read(IOSC_CAL_ADDR, rdat);
                check8(rdat, 8'h7F, "cal bit 7 not dropped");
                check8({1'b0, internal_osc_calibration_o}, 8'h7F, "cal output");
                wait_ready();
                measure_period(per);
                measure_period(per);
                // Half a percent of the base period per step; model truncates to whole cycles
                per_lo = 2 * OSC_HALF_BASE * (1000 + CAL_STEP_PERMILLE *
                         (int'(7'h7F) - int'(CAL_UNCAL_RESET))) / 1000;
                check_int(int'(per >= per_lo && per <= per_lo + 1), 1, "cal step");
                sfr_write(IOSC_CAL_ADDR, 8'h20);
                // External source with internal oscillator off, junk in unused bits
                sfr_write(IOSC_CTRL_ADDR, 8'hEB);
                sfr_read(IOSC_CTRL_ADDR, rdat);
                check8(rdat, 8'h0B, "control after external select");
                check8({6'h00, internal_osc_enable_o, internal_osc_ready_flag_o}, 8'h00,
                       "disabled oscillator still ready");
                measure_period(per);
                measure_period(per);
                check_int(per, EXT_PERIOD, "external clock rate");
                // Unmapped place: write ignored, read gives zero
                sfr_write(8'hB4, 8'h55);
                sfr_read(8'hB4, rdat);
                check8(rdat, 8'h00, "unmapped read");
                sfr_read(IOSC_CTRL_ADDR, rdat);
                check8(rdat, 8'h0B, "control disturbed by unmapped write");
                // Enable and select internal in the same write
                sfr_write(IOSC_CTRL_ADDR, 8'h07);
                wait_ready();
                sfr_read(IOSC_CTRL_ADDR, rdat);
                check8(rdat, 8'h17, "control after switch back");
                measure_period(per);
                measure_period(per);
                check_int(per, 2 * OSC_HALF_BASE, "internal clock after switch");
                // Second reset in mid-run
                @(posedge clk_i);
                #STEP_NS;
                rst_n_i = 1'b0;
                repeat (2) @(posedge clk_i);
                #STEP_NS;
                rst_n_i = 1'b1;
            end
        end
        tally_and_finish();
    end
endmodule // iosc_ctrl_tb
